// >>> verilog/acc_pkg.sv
// constants for the converter sample/convert control block
package acc_pkg;
  localparam logic [7:0] ACC_CTRL1_OFS = 8'h00;
  localparam logic [7:0] ACC_RESULT_OFS = 8'h04;
  localparam logic [7:0] ACC_STATUS_OFS = 8'h08;
  localparam int ACC_ON_BIT = 15;
  localparam int ACC_STOP_IN_IDLE_BIT = 13;
  localparam int ACC_OUTPUT_FORMAT_SELECT_LSB = 8;
  localparam int ACC_TRIGGER_SOURCE_SELECT_LSB = 5;
  localparam int ACC_STOP_AFTER_FIRST_INTERRUPT_BIT = 4;
  localparam int ACC_AUTO_SAMPLE_START_BIT = 2;
  localparam int ACC_SAMPLE_ENABLE_BIT = 1;
  localparam int ACC_DONE_BIT = 0;
  localparam logic [31:0] ACC_CTRL1_RESET = 32'h0000_0000;
  localparam logic [31:0] ACC_CTRL1_WMASK = 32'h0000_a7f7;
  localparam logic [2:0] ACC_FMT_INT16 = 3'h0;
  localparam logic [2:0] ACC_FMT_FRAC16 = 3'h2;
  localparam logic [2:0] ACC_FMT_SFRAC16 = 3'h3;
  localparam logic [2:0] ACC_FMT_INT32 = 3'h4;
  localparam logic [2:0] ACC_FMT_SINT32 = 3'h5;
  localparam logic [2:0] ACC_FMT_FRAC32 = 3'h6;
  localparam logic [2:0] ACC_FMT_SFRAC32 = 3'h7;
  localparam logic [2:0] ACC_TRG_SOFT = 3'h0;
  localparam logic [2:0] ACC_TRG_EXTINT = 3'h1;
  localparam logic [2:0] ACC_TRG_TIMER3 = 3'h2;
  localparam logic [2:0] ACC_TRG_CHARGE = 3'h3;
  localparam logic [2:0] ACC_TRG_AUTO = 3'h7;
  localparam int ACC_AUTO_SAMPLE_CYCLES = 16;
endpackage : acc_pkg

// >>> verilog/acc_ctrl.sv
// converter control register one with sample/convert sequencing
//
// How it works
// - converter runs only while enable bit set
// - stop_in_idle halts converter during idle
// - 16-bit formats: integer, fraction, signed fraction
// - 32-bit formats: int, signed int, fractions
// - trigger 111: internal counter ends sampling
// - trigger 011/010/001: charge unit, timer3, pin
// - trigger 000: writing sample_enable zero converts
// - stop_after_first_interrupt clears auto_sample_start on done
// - otherwise results keep overwriting earlier ones
// - auto_sample_start resamples after each conversion
// - else sampling starts on software write one
// - trigger 001/010/011/111 clears sample_enable in hardware
// - sample_enable reads one while sampling
// - done flag set at conversion completion
// - software clears done by writing zero
// - done cleared when new conversion starts
// - unimplemented bits ignore writes, read zero
`timescale 1ns/1ps
module acc_ctrl #(
  parameter int AUTO_CYCLES = acc_pkg::ACC_AUTO_SAMPLE_CYCLES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // chip state
  input wire logic idle_mode_i,
  // trigger sources
  input wire logic ext_int_zero_pin_i,
  input wire logic timer3_match_i,
  input wire logic charge_time_event_i,
  // analog engine
  output logic sample_hold_o,
  output logic convert_start_o,
  input wire logic convert_done_i,
  input wire logic [9:0] convert_result_i,
  // formatted output and interrupt
  output logic [31:0] result_word_o,
  output logic convert_irq_o
);
  typedef enum logic [1:0] {
    ACC_ST_IDLE = 2'b00,
    ACC_ST_SAMPLE = 2'b01,
    ACC_ST_CONVERT = 2'b10
  } acc_state_t;

  acc_state_t state_ff, nxt_state;
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [31:0] result_ff;
  logic [15:0] auto_cnt_ff, nxt_auto_cnt;
  logic wr_pend_ff;
  logic [7:0] addr_ff;
  logic irq_ff;
  logic pin_prev_ff;
  logic start_ff;
  logic [31:0] rdata_ff;
  wire logic [2:0] pin_sync;

  // bus decode
  wire logic bus_take = hsel_i & hready_i & htrans_i[1];
  wire logic wr_ctrl = wr_pend_ff & (addr_ff == acc_pkg::ACC_CTRL1_OFS);
  wire logic [31:0] wdata_m = hwdata_i & acc_pkg::ACC_CTRL1_WMASK;
  // hsize is not decoded: every access is taken as a whole word

  // control fields
  wire logic on_b = ctrl_ff[acc_pkg::ACC_ON_BIT];
  wire logic stop_in_idle_b = ctrl_ff[acc_pkg::ACC_STOP_IN_IDLE_BIT];
  wire logic [2:0] output_format_select_f = ctrl_ff[acc_pkg::ACC_OUTPUT_FORMAT_SELECT_LSB +: 3];
  wire logic [2:0] trigger_source_select_f = ctrl_ff[acc_pkg::ACC_TRIGGER_SOURCE_SELECT_LSB +: 3];
  wire logic stop_after_first_interrupt_b = ctrl_ff[acc_pkg::ACC_STOP_AFTER_FIRST_INTERRUPT_BIT];
  wire logic auto_sample_start_b = ctrl_ff[acc_pkg::ACC_AUTO_SAMPLE_START_BIT];
  wire logic sample_enable_b = ctrl_ff[acc_pkg::ACC_SAMPLE_ENABLE_BIT];
  wire logic run = on_b & ~(stop_in_idle_b & idle_mode_i);

  // external pins pass two flops; edge detect reads only the second
  wire logic [2:0] pin_raw = {charge_time_event_i, timer3_match_i, ext_int_zero_pin_i};
  wire logic ext_int_s = pin_sync[0];
  wire logic tmr_s = pin_sync[1];
  wire logic charge_time_unit_s = pin_sync[2];
  wire logic ext_edge = ext_int_s & ~pin_prev_ff;

  // hardware trigger select; reserved codes match nothing
  wire logic auto_hit = (auto_cnt_ff >= 16'(AUTO_CYCLES - 1));
  wire logic hw_trig =
    (trigger_source_select_f == acc_pkg::ACC_TRG_EXTINT) ? ext_edge :
    (trigger_source_select_f == acc_pkg::ACC_TRG_TIMER3) ? tmr_s :
    (trigger_source_select_f == acc_pkg::ACC_TRG_CHARGE) ? charge_time_unit_s :
    (trigger_source_select_f == acc_pkg::ACC_TRG_AUTO) ? auto_hit :
    1'b0;

  // software sample_enable writes
  wire logic sw_sample_enable_set = wr_ctrl & wdata_m[acc_pkg::ACC_SAMPLE_ENABLE_BIT] & ~auto_sample_start_b;
  wire logic sw_sample_enable_clr = wr_ctrl & ~wdata_m[acc_pkg::ACC_SAMPLE_ENABLE_BIT] & sample_enable_b
                         & (trigger_source_select_f == acc_pkg::ACC_TRG_SOFT);
  wire logic in_sample = (state_ff == ACC_ST_SAMPLE);
  wire logic end_sample = run & in_sample & ((trigger_source_select_f == acc_pkg::ACC_TRG_SOFT)
                          ? sw_sample_enable_clr : hw_trig);
  wire logic done_evt = run & (state_ff == ACC_ST_CONVERT) & convert_done_i;

  // formatting
  function automatic logic [31:0] acc_format(input logic [2:0] f, input logic [9:0] d);
    logic [9:0] s;
    s = {~d[9], d[8:0]};
    unique case (f)
      acc_pkg::ACC_FMT_INT16: acc_format = {22'h0, d};
      acc_pkg::ACC_FMT_FRAC16: acc_format = {16'h0, d, 6'h0};
      acc_pkg::ACC_FMT_SFRAC16: acc_format = {16'h0, s, 6'h0};
      acc_pkg::ACC_FMT_INT32: acc_format = {22'h0, d};
      acc_pkg::ACC_FMT_SINT32: acc_format = {{22{s[9]}}, s};
      acc_pkg::ACC_FMT_FRAC32: acc_format = {d, 22'h0};
      acc_pkg::ACC_FMT_SFRAC32: acc_format = {s, 22'h0};
      default: acc_format = {22'h0, d};
    endcase
  endfunction : acc_format

  // sequencer
  // leaving run drops a conversion in flight and ignores its done
  always_comb begin
    nxt_state = state_ff;
    nxt_auto_cnt = '0;
    if (!run) begin
      nxt_state = ACC_ST_IDLE;
    end else begin
      unique case (state_ff)
        ACC_ST_IDLE: begin
          if (sw_sample_enable_set || auto_sample_start_b) begin
            nxt_state = ACC_ST_SAMPLE;
          end
        end
        ACC_ST_SAMPLE: begin
          nxt_auto_cnt = auto_hit ? '0 : auto_cnt_ff + 16'h0001;
          if (end_sample) begin
            nxt_state = ACC_ST_CONVERT;
          end
        end
        ACC_ST_CONVERT: begin
          if (convert_done_i) begin
            nxt_state = (auto_sample_start_b && !stop_after_first_interrupt_b) ? ACC_ST_SAMPLE : ACC_ST_IDLE;
          end
        end
        default: nxt_state = ACC_ST_IDLE;
      endcase
    end
  end

  // control register update; hardware set wins over software clear
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl) begin
      nxt_ctrl = (wdata_m & ~32'h0000_0003) | (ctrl_ff & 32'h0000_0003);
      if (!wdata_m[acc_pkg::ACC_DONE_BIT]) begin
        nxt_ctrl[acc_pkg::ACC_DONE_BIT] = 1'b0;
      end
    end
    nxt_ctrl[acc_pkg::ACC_SAMPLE_ENABLE_BIT] = (nxt_state == ACC_ST_SAMPLE);
    if (end_sample) begin
      nxt_ctrl[acc_pkg::ACC_DONE_BIT] = 1'b0;
    end
    if (done_evt) begin
      nxt_ctrl[acc_pkg::ACC_DONE_BIT] = 1'b1;
      if (stop_after_first_interrupt_b) begin
        nxt_ctrl[acc_pkg::ACC_AUTO_SAMPLE_START_BIT] = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_ff <= ACC_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_ff <= acc_pkg::ACC_CTRL1_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      auto_cnt_ff <= '0;
    end else begin
      auto_cnt_ff <= nxt_auto_cnt;
    end
  end

  // result overwritten by every conversion; an unread result is lost
  wire logic [31:0] nxt_result = done_evt ? acc_format(output_format_select_f, convert_result_i) : result_ff;
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      result_ff <= '0;
    end else begin
      result_ff <= nxt_result;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= done_evt;
    end
  end

  // one two-flop synchroniser per trigger pin
  for (genvar g = 0; g < 3; g++) begin : g_pin_sync
    logic meta_ff;
    logic sync_ff;
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        meta_ff <= 1'b0;
        sync_ff <= 1'b0;
      end else begin
        meta_ff <= pin_raw[g];
        sync_ff <= meta_ff;
      end
    end
    assign pin_sync[g] = sync_ff;
  end

  // reset level matches the idle low pin, so no false edge after reset
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_prev_ff <= 1'b0;
    end else begin
      pin_prev_ff <= ext_int_s;
    end
  end

  // bus data phase, zero wait states
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_pend_ff <= 1'b0;
    end else begin
      wr_pend_ff <= bus_take & hwrite_i;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      addr_ff <= '0;
    end else begin
      addr_ff <= haddr_i[7:0];
    end
  end

  // reads sample next-state values, so a read right behind a write sees the new word
  wire logic rd_take = bus_take & ~hwrite_i;
  wire logic [7:0] rd_addr = haddr_i[7:0];
  wire logic [31:0] rd_status = {29'h0, done_evt, nxt_state};
  wire logic [31:0] nxt_rdata = !rd_take ? 32'h0 :
    (rd_addr == acc_pkg::ACC_CTRL1_OFS) ? nxt_ctrl :
    (rd_addr == acc_pkg::ACC_RESULT_OFS) ? nxt_result :
    (rd_addr == acc_pkg::ACC_STATUS_OFS) ? rd_status : 32'h0;
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign hrdata_o = rdata_ff;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  // engine side
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      start_ff <= 1'b0;
    end else begin
      start_ff <= end_sample;
    end
  end
  assign sample_hold_o = sample_enable_b;
  assign convert_start_o = start_ff;
  assign result_word_o = result_ff;
  assign convert_irq_o = irq_ff;
endmodule : acc_ctrl

// >>> sim/acc_props.sv
// concurrent checks on the converter control ports
`timescale 1ns/1ps
module acc_props (
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // bus
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // engine
  input wire logic sample_hold_o,
  input wire logic convert_start_o,
  input wire logic convert_done_i,
  input wire logic convert_irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  logic rd_ff;
  logic [7:0] ra_ff;
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_ff <= 1'b0;
      ra_ff <= 8'h00;
    end else begin
      rd_ff <= hsel_i & hready_i & htrans_i[1] & ~hwrite_i;
      ra_ff <= haddr_i[7:0];
    end
  end
  a_bus_okay: assert property (hreadyout_o && !hresp_o) else $error("bus stalled");
  a_start_one_pulse: assert property (convert_start_o |=> !convert_start_o)
    else $error("start longer than a cycle");
  a_start_ends_hold: assert property (
    convert_start_o |-> !sample_hold_o && $past(sample_hold_o))
    else $error("start without end of sampling");
  a_irq_after_done: assert property (convert_irq_o |-> $past(convert_done_i))
    else $error("irq without done");
  a_irq_one_pulse: assert property (convert_irq_o |=> !convert_irq_o)
    else $error("irq longer than a cycle");
  a_idle_bus_zero: assert property (!rd_ff |-> hrdata_o == 32'h0) else $error("read data outside read");
  a_unmapped_zero: assert property (rd_ff && ra_ff == 8'h0c |-> hrdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_spare_bits_zero: assert property (
    rd_ff && ra_ff == 8'h00 |-> (hrdata_o & 32'hffff_5808) == 32'h0)
    else $error("spare bits not zero");
  cover property (convert_start_o);
  cover property (convert_irq_o ##[1:20] sample_hold_o);
  cover property ($rose(sample_hold_o));
endmodule : acc_props
bind acc_ctrl acc_props u_props (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
  .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .sample_hold_o(sample_hold_o), .convert_start_o(convert_start_o),
  .convert_done_i(convert_done_i), .convert_irq_o(convert_irq_o));

// >>> sim/acc_engine_model.sv
// behavioural analog engine answering each start
`timescale 1ns/1ps
module acc_engine_model (
  // clock and start
  input wire logic clock_i,
  input wire logic start_i,
  input wire logic [9:0] value_i,
  input wire logic [4:0] delay_i,
  // answer
  output logic done_o,
  output logic [9:0] result_o
);
  initial begin
    done_o = 1'b0;
    result_o = 10'h000;
    forever begin
      @(posedge clock_i);
      if (start_i === 1'b1) begin
        repeat (delay_i) @(posedge clock_i);
        done_o <= 1'b1;
        result_o <= value_i;
        @(posedge clock_i);
        done_o <= 1'b0;
        result_o <= ~value_i; // stale data must not look valid
      end
    end
  end
endmodule : acc_engine_model

// >>> sim/acc_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module testbench;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic hsel_i = 1'b0;
  logic hwrite_i = 1'b0;
  logic idle_i = 1'b0;
  logic [2:0] trig_i = 3'h0;
  logic [1:0] htrans_i = 2'h0;
  logic [31:0] haddr_i = 32'h0;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] x = 32'd58799;
  logic [31:0] hrdata_o, word_o, q, w;
  logic [9:0] val = 10'h0;
  logic [9:0] res_i;
  logic [4:0] dly = 5'h1;
  logic rdy_o, resp_o, hold_o, start_o, done_i, irq_o;
  logic [2:0] fm [7] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  int tl [4] = '{1, 2, 3, 7};
  int mismatches = 0, check_count = 0, cyc = 0, starts = 0, irqs = 0;
  acc_ctrl #(.AUTO_CYCLES(4)) uut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
    .hwdata_i(hwdata_i), .hready_i(rdy_o), .hrdata_o(hrdata_o), .hreadyout_o(rdy_o),
    .hresp_o(resp_o), .idle_mode_i(idle_i), .ext_int_zero_pin_i(trig_i[0]),
    .timer3_match_i(trig_i[1]), .charge_time_event_i(trig_i[2]), .sample_hold_o(hold_o),
    .convert_start_o(start_o), .convert_done_i(done_i), .convert_result_i(res_i),
    .result_word_o(word_o), .convert_irq_o(irq_o));
  acc_engine_model u_eng (.clock_i(clock_i), .start_i(start_o), .value_i(val), .delay_i(dly),
    .done_o(done_i), .result_o(res_i));
  initial forever #2.5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc++;
    starts += start_o;
    irqs += irq_o;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  function automatic logic [31:0] rnd(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : rnd
  function automatic logic [31:0] fmt(input logic [2:0] m, input logic [9:0] r);
    logic [9:0] s;
    s = {~r[9], r[8:0]}; // offset binary to two's complement
    case (m)
      3'h2: return {16'h0, r, 6'h0};
      3'h3: return {16'h0, s, 6'h0};
      3'h5: return {{22{s[9]}}, s};
      3'h6: return {r, 22'h0};
      3'h7: return {s, 22'h0};
      default: return {22'h0, r};
    endcase
  endfunction : fmt
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= {24'h0, a};
    hwrite_i <= wr;
    @(posedge clock_i);
    while (rdy_o !== 1'b1) @(posedge clock_i);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    @(posedge clock_i);
    while (rdy_o !== 1'b1) @(posedge clock_i);
    q = hrdata_o;
  endtask : bus
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task rdc(input logic [31:0] e);
    bus(1'b0, 8'h00, 32'h0);
    chk("control", e, q);
  endtask : rdc
  task wirq;
    for (int i = 0; i < 200 && irq_o !== 1'b1; i++) @(posedge clock_i);
    chk("irq", 32'h1, {31'h0, irq_o});
  endtask : wirq
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (8) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    @(posedge clock_i);
    rdc(32'h0);
    bus(1'b0, 8'h0c, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'b1, 8'h00, 32'hffff_7ff9);
    rdc(32'h0000_27f0);
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      x = rnd(x);
      val <= x[9:0];
      dly <= {2'h0, x[12:10]} + 5'h1;
      w = 32'h8000 | (32'(fm[i]) << 8);
      bus(1'b1, 8'h00, w);
      bus(1'b1, 8'h00, w | 32'h2);
      rdc(w | 32'h2);
      chk("hold", 32'h1, {31'h0, hold_o});
      bus(1'b1, 8'h00, w);
      wirq();
      repeat (2) @(posedge clock_i);
      chk("result", fmt(fm[i], val), word_o);
      bus(1'b0, 8'h04, 32'h0);
      chk("result reg", fmt(fm[i], val), q);
      rdc(w | 32'h1);
      bus(1'b1, 8'h00, w);
      rdc(w);
    end
    $display("test formats done");
    foreach (tl[i]) begin
      w = 32'h8000 | (32'(tl[i]) << 5);
      bus(1'b1, 8'h00, w | 32'h2);
      trig_i <= 3'(1 << (tl[i] - 1));
      repeat (4) @(posedge clock_i);
      trig_i <= 3'h0;
      wirq();
      rdc(w | 32'h1);
    end
    bus(1'b1, 8'h00, 32'h80a2);
    trig_i <= 3'h7;
    repeat (30) @(posedge clock_i);
    trig_i <= 3'h0;
    rdc(32'h80a2);
    $display("test triggers done");
    bus(1'b1, 8'h00, 32'h80f6);
    wirq();
    @(posedge clock_i);
    irqs = 0;
    repeat (40) @(posedge clock_i);
    chk("extra irqs", 32'h0, irqs);
    rdc(32'h80f1);
    bus(1'b1, 8'h00, 32'h80e6);
    irqs = 0;
    repeat (150) @(posedge clock_i);
    chk("repeats", 32'h1, {31'h0, irqs >= 3});
    bus(1'b1, 8'h00, 32'ha0e6);
    idle_i <= 1'b1;
    repeat (5) @(posedge clock_i);
    starts = 0;
    repeat (60) @(posedge clock_i);
    chk("idle starts", 32'h0, starts);
    idle_i <= 1'b0;
    bus(1'b1, 8'h00, 32'h00e6);
    repeat (5) @(posedge clock_i);
    starts = 0;
    repeat (60) @(posedge clock_i);
    chk("off starts", 32'h0, starts);
    $display("test auto done");
    print_verdict();
  end
endmodule : testbench
